// >>> include/sac_pkg.sv
/*
  Shared constants for the successive-approximation converter control:
  control register field positions, reset values, timing in machine cycles.
  Assumes the processor core drives the control bits on the same clock.
*/
// Behaviour
// [R1] eight-input mux, ten-bit binary successive approximation
// [R2] conversion lasts 50, or 24 fast variant
// [R3] four machine cycles per tested bit; the fast variant uses one
// [R4] sample selected input eight machine cycles first
// [R5] start with only the top bit set
// [R6] walk lower bits; result stays in register
// [R7] three low control bits pick channel
// [R8] software bit or enabled pin edge starts
// [R9] pin start begins next machine cycle
// [R10] software start begins following machine cycle
// [R11] start bit: command flop, separate status flop
// [R12] upper byte in result, low two in control
// [R13] software clears complete flag, never sets it
// [R14] interrupt request gated by its enable bit
// [R15] idle mode aborts running conversion
// [R16] finish: clear busy, latch, flag together
// [R17] starts ignored while conversion in progress
package sac_pkg;

  // ************************************************************
  // conversion geometry and timing
  // ************************************************************
  localparam int RESULT_BITS    = 10;
  localparam int CHAN_BITS      = 3;
  localparam int CLKS_PER_MC_DF = 12;
  localparam int SAMPLE_MC      = 8;
  localparam int BIT_MC_STD     = 4;
  localparam int BIT_MC_FAST    = 1;
  localparam int CONV_MC_STD    = 50;
  localparam int CONV_MC_FAST   = 24;
  localparam int PHASE_W        = 6;

  // ************************************************************
  // control register layout
  // ************************************************************
  localparam int CTRL_CHAN_LSB  = 0;
  localparam int CTRL_START_BIT = 3;
  localparam int CTRL_DONE_BIT  = 4;
  localparam int CTRL_EXT_BIT   = 5;
  localparam int CTRL_LOW_LSB   = 6;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [RESULT_BITS-1:0] SAR_RST    = 10'h000;
  localparam logic [RESULT_BITS-1:0] SAR_MSB    = 10'h200;
  localparam logic [7:0]             RESULT_RST = 8'h00;
  localparam logic [1:0]             LOW_RST    = 2'h0;

endpackage

// >>> include/sac_sar_if.sv
/*
  Carrier between the conversion sequencer and the approximation engine.
  Assumes both ends share one clock and reset.
*/
`timescale 1ns/1ns
interface sac_sar_if
  import sac_pkg::*;
();
  logic                   begin_approx;
  logic                   decide;
  logic                   above;
  logic                   last_bit;
  logic [RESULT_BITS-1:0] trial;

  modport ctrl
  (
    output begin_approx,
    output decide,
    output above,
    input  last_bit,
    input  trial
  );

  modport engine
  (
    input  begin_approx,
    input  decide,
    input  above,
    output last_bit,
    output trial
  );
endinterface

// >>> rtl/sac_mcycle.sv
/*
  Machine cycle divider: one tick on the last clock of every machine cycle.
  Assumes a synchronised active-low reset.
*/
`timescale 1ns/1ns
module sac_mcycle
  import sac_pkg::*;
#(
  parameter int CLKS_PER_MC = CLKS_PER_MC_DF
)
(
  input  wire logic clk,
  input  wire logic rst_n,
  output logic      mc_tick
);

  localparam int CW = $clog2(CLKS_PER_MC + 1);
  localparam logic [CW-1:0] LAST = CW'(CLKS_PER_MC - 1);

  logic [CW-1:0] count;
  wire  logic    at_last = (count == LAST);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      count <= '0;
    else
      count <= at_last ? '0 : count + CW'(1);
  end

  assign mc_tick = at_last;

endmodule

// >>> rtl/sac_sar.sv
/*
  Successive approximation register with its bit pointer.
  Assumes the sequencer pulses begin and decide on machine cycle ends.
*/
`timescale 1ns/1ns
module sac_sar
  import sac_pkg::*;
(
  input  wire logic  clk,
  input  wire logic  rst_n,
  sac_sar_if.engine  sar
);

  localparam int PW = $clog2(RESULT_BITS);

  logic [RESULT_BITS-1:0] value;
  logic [PW-1:0]          ptr;

  // ************************************************************
  // trial update
  // ************************************************************
  wire logic [RESULT_BITS-1:0] cur_mask  = SAR_MSB >> (RESULT_BITS - 1 - ptr);
  wire logic [RESULT_BITS-1:0] kept      = sar.above ? value
                                                     : (value & ~cur_mask);
  wire logic [RESULT_BITS-1:0] next_val  = (ptr == '0) ? kept
                                                       : (kept | (cur_mask >> 1));

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      value <= SAR_RST;
      ptr   <= '0;
    end
    else if (sar.begin_approx)
    begin
      value <= SAR_MSB; // [R5]
      ptr   <= PW'(RESULT_BITS - 1);
    end
    else if (sar.decide)
    begin
      // keep on greater, clear otherwise, then try the next lower bit
      value <= next_val; // [R6]
      if (ptr != '0)
        ptr <= ptr - PW'(1);
    end
  end

  assign sar.trial    = value; // [R1]
  assign sar.last_bit = (ptr == '0);

endmodule

// >>> rtl/sac_top.sv
/*
  Converter control: start logic, sample window, bit sequencing, result and
  complete flag, interrupt request.
  Assumes the core drives its control bits on clk; the start pin and the
  comparator output are asynchronous and are synchronised here.
*/
`timescale 1ns/1ns
module sac_top
  import sac_pkg::*;
#(
  parameter int CLKS_PER_MC  = CLKS_PER_MC_DF,
  parameter bit FAST_VARIANT = 1'b0
)
(
  input  wire logic                   clk,
  input  wire logic                   reset_n,
  input  wire logic [CHAN_BITS-1:0]   channel_sel,
  input  wire logic                   ext_start_en,
  input  wire logic                   start_set,
  input  wire logic                   complete_clr,
  input  wire logic                   converter_irq_enable,
  input  wire logic                   idle_mode,
  input  wire logic                   external_start_pin,
  input  wire logic                   comparator_above,
  output logic [CHAN_BITS-1:0]        analog_channel,
  output logic                        sample_switch,
  output logic [RESULT_BITS-1:0]      trial_voltage,
  output logic [7:0]                  converter_control_reg,
  output logic [7:0]                  result_high_byte,
  output logic                        irq_request
);

  // ************************************************************
  // variant timing
  // ************************************************************
  localparam int BIT_MC  = FAST_VARIANT ? BIT_MC_FAST : BIT_MC_STD;
  localparam int CONV_MC = FAST_VARIANT ? CONV_MC_FAST : CONV_MC_STD;
  // remainder after sampling and bit tests; must be one or more
  localparam int TAIL_MC = CONV_MC - SAMPLE_MC - RESULT_BITS * BIT_MC;

  localparam logic [PHASE_W-1:0] SAMPLE_LAST = PHASE_W'(SAMPLE_MC - 1);
  localparam logic [PHASE_W-1:0] BIT_LAST    = PHASE_W'(BIT_MC - 1);
  localparam logic [PHASE_W-1:0] TAIL_LAST   = PHASE_W'(TAIL_MC - 1);

  typedef enum logic [1:0]
  {
    ST_IDLE,
    ST_SAMPLE,
    ST_APPROX,
    ST_TAIL
  } sac_state_e;

  // ************************************************************
  // helpers
  // ************************************************************
  // true on the tick that closes the last machine cycle of a phase;
  // shared by sample, bit and tail ends so they cannot drift apart
  function automatic logic phase_last
  (
    input logic               in_state,
    input logic               tick,
    input logic [PHASE_W-1:0] count,
    input logic [PHASE_W-1:0] last
  );
    return in_state & tick & (count == last);
  endfunction

  // ************************************************************
  // reset release and input synchronisers
  // ************************************************************
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // the comparator path lags three clocks (trial flop and two sync
  // flops), so the fast variant needs four clocks per machine cycle
  logic pin_meta;
  logic pin_sync;
  logic pin_prev;
  logic cmp_meta;
  logic cmp_sync;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
      pin_prev <= 1'b0;
      cmp_meta <= 1'b0;
      cmp_sync <= 1'b0;
    end
    else
    begin
      pin_meta <= external_start_pin;
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
      cmp_meta <= comparator_above;
      cmp_sync <= cmp_meta;
    end
  end

  // ************************************************************
  // machine cycle timing and approximation engine
  // ************************************************************
  logic mc_tick;

  sac_mcycle #(
    .CLKS_PER_MC (CLKS_PER_MC)
  ) u_mcycle (
    .clk     (clk),
    .rst_n   (rst_n),
    .mc_tick (mc_tick)
  );

  sac_sar_if sar_bus ();

  sac_sar u_sar (
    .clk   (clk),
    .rst_n (rst_n),
    .sar   (sar_bus.engine)
  );

  // ************************************************************
  // state and decode
  // ************************************************************
  sac_state_e        state;
  sac_state_e        next_state;
  logic [PHASE_W-1:0] phase;
  logic              start_cmd;
  logic              busy;
  logic              done_flag;
  logic [1:0]        result_low;

  // edge taken from the synchronised copy, two clocks after the pin
  wire logic pin_rise    = pin_sync & ~pin_prev;
  wire logic ext_request = pin_rise & ext_start_en; // [R8]
  wire logic set_request = (start_set | ext_request) & ~busy; // [R17]
  wire logic start_go    = mc_tick & start_cmd & ~busy & ~idle_mode; // [R9] [R10]
  wire logic abort       = idle_mode & busy; // [R15]

  wire logic in_sample   = (state == ST_SAMPLE);
  wire logic in_approx   = (state == ST_APPROX);
  wire logic in_tail     = (state == ST_TAIL);

  wire logic sample_end  =
    phase_last(in_sample, mc_tick, phase, SAMPLE_LAST); // [R4]
  wire logic bit_end     =
    phase_last(in_approx, mc_tick, phase, BIT_LAST); // [R3]
  wire logic tail_end    =
    phase_last(in_tail, mc_tick, phase, TAIL_LAST); // [R2]
  // idle wins over a finish in the same tick: no flag, result kept
  wire logic finish      = tail_end & ~idle_mode;
  wire logic state_moves = (next_state != state);

  // ************************************************************
  // sequencer
  // ************************************************************
  always_comb
  begin
    next_state = state;
    case (state)
      ST_IDLE:
        if (start_go)
          next_state = ST_SAMPLE;
      ST_SAMPLE:
        if (sample_end)
          next_state = ST_APPROX;
      ST_APPROX:
        if (bit_end && sar_bus.last_bit)
          next_state = ST_TAIL;
      ST_TAIL:
        if (tail_end)
          next_state = ST_IDLE;
      default:
        next_state = ST_IDLE;
    endcase
    if (abort)
      next_state = ST_IDLE;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      state <= ST_IDLE;
    else
      state <= next_state;
  end

  // phase counts machine cycles inside one state or one bit
  wire logic [PHASE_W-1:0] next_phase =
    (state_moves || bit_end) ? '0 :
    mc_tick                  ? phase + PHASE_W'(1) :
                               phase;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      phase <= '0;
    else
      phase <= next_phase;
  end

  assign sar_bus.begin_approx = sample_end & ~idle_mode; // [R5]
  assign sar_bus.decide       = bit_end & ~idle_mode; // [R6]
  assign sar_bus.above        = cmp_sync;

  // ************************************************************
  // start bit: command flop and status flop
  // ************************************************************
  // a pending command is dropped in idle so it cannot fire on wake-up
  wire logic next_cmd  = (start_cmd | set_request) & ~start_go & ~idle_mode;
  wire logic next_busy = start_go ? 1'b1 :
                         (finish | abort) ? 1'b0 : busy; // [R16]

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      start_cmd <= 1'b0;
      busy      <= 1'b0;
    end
    else
    begin
      start_cmd <= next_cmd; // [R11]
      busy      <= next_busy; // [R11]
    end
  end

  // ************************************************************
  // result and complete flag
  // ************************************************************
  // hardware set wins over a clear in the same cycle
  wire logic next_done = finish | (done_flag & ~complete_clr); // [R13] [R16]

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      done_flag        <= 1'b0;
      result_high_byte <= RESULT_RST;
      result_low       <= LOW_RST;
    end
    else
    begin
      done_flag <= next_done;
      if (finish)
      begin
        result_high_byte <= sar_bus.trial[RESULT_BITS-1 -: 8]; // [R12] [R16]
        result_low       <= sar_bus.trial[1:0]; // [R12]
      end
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  logic [7:0] next_ctrl;

  always_comb
  begin
    next_ctrl = 8'h00;
    next_ctrl[CTRL_CHAN_LSB +: CHAN_BITS] = channel_sel;
    next_ctrl[CTRL_START_BIT]             = next_busy;
    next_ctrl[CTRL_DONE_BIT]              = next_done;
    next_ctrl[CTRL_EXT_BIT]               = ext_start_en;
    next_ctrl[CTRL_LOW_LSB +: 2]          = finish ? sar_bus.trial[1:0]
                                                   : result_low;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      analog_channel        <= '0;
      sample_switch         <= 1'b0;
      trial_voltage         <= SAR_RST;
      converter_control_reg <= 8'h00;
    end
    else
    begin
      // channel follows the control bits; sampling uses what is selected
      analog_channel        <= channel_sel; // [R7]
      sample_switch         <= (next_state == ST_SAMPLE); // [R4]
      trial_voltage         <= sar_bus.trial; // [R1]
      converter_control_reg <= next_ctrl; // [R11] [R12]
    end
  end

  // global interrupt masking is left to the core
  assign irq_request = done_flag & converter_irq_enable; // [R14]

endmodule

// >>> verification/sac_afe_model.sv
/* analog side model: eight input levels, sample and hold, comparator.
   assumes the bench drives the levels and keeps them steady */
`timescale 1ns/1ns
module sac_afe_model
  import sac_pkg::*;
(
  input  wire logic [7:0][RESULT_BITS-1:0] level,
  input  wire logic [CHAN_BITS-1:0]        analog_channel,
  input  wire logic                        sample_switch,
  input  wire logic [RESULT_BITS-1:0]      trial_voltage,
  output logic                             comparator_above
);
  logic [RESULT_BITS-1:0] held = 10'h000;
  // tracks only while the switch is closed
  always_latch
    if (sample_switch)
      held <= level[analog_channel];
  assign comparator_above = held > trial_voltage;
endmodule

// >>> verification/sac_properties.sv
/* port checker for sac_top, bound to every instance at the foot.
   assumes the names of the top ports as declared by the design */
`timescale 1ns/1ns
module sac_properties
  import sac_pkg::*;
#(
  parameter int CLKS_PER_MC  = CLKS_PER_MC_DF,
  parameter bit FAST_VARIANT = 1'b0
)
(
  input logic                   clk,
  input logic                   reset_n,
  input logic [CHAN_BITS-1:0]   channel_sel,
  input logic                   ext_start_en,
  input logic                   start_set,
  input logic                   complete_clr,
  input logic                   converter_irq_enable,
  input logic                   idle_mode,
  input logic                   external_start_pin,
  input logic                   comparator_above,
  input logic [CHAN_BITS-1:0]   analog_channel,
  input logic                   sample_switch,
  input logic [RESULT_BITS-1:0] trial_voltage,
  input logic [7:0]             converter_control_reg,
  input logic [7:0]             result_high_byte,
  input logic                   irq_request
);
  localparam int TOTAL  = CLKS_PER_MC *
                          (FAST_VARIANT ? CONV_MC_FAST : CONV_MC_STD);
  localparam int SMP    = SAMPLE_MC * CLKS_PER_MC;
  localparam int SW_MAX = CLKS_PER_MC + 2;
  wire busy = converter_control_reg[CTRL_START_BIT];
  wire done = converter_control_reg[CTRL_DONE_BIT];
  int  bcnt;
  int  scnt;
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      bcnt <= 0;
      scnt <= 0;
    end
    else
    begin
      bcnt <= busy ? bcnt + 1 : 0;
      scnt <= sample_switch ? scnt + 1 : 0;
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  // ****
  // properties
  // ****
  // aborted runs never raise the flag, so lengths skip them
  sequence s_finish;
    $fell(busy) ##0 $rose(done);
  endsequence
  sequence s_sample_end;
    $fell(sample_switch) ##0 busy;
  endsequence
  conv_length_a:
    assert property (s_finish |-> bcnt == TOTAL) else $error("bad length");
  sample_length_a:
    assert property (s_sample_end |-> scnt == SMP) else $error("bad sample");
  sample_open_a:
    assert property ($rose(busy) |-> sample_switch) else $error("no sample");
  msb_first_a:
    assert property (s_sample_end |-> ##[0:2] trial_voltage == SAR_MSB)
      else $error("first trial not top bit");
  finish_flag_a:
    assert property ($fell(busy) && !$past(idle_mode) &&
      !$past(idle_mode, 2) |-> done) else $error("finish without flag");
  hw_only_set_a:
    assert property ($rose(done) |-> $fell(busy)) else $error("stray flag");
  flag_clear_a:
    assert property (complete_clr && !busy |=> !done)
      else $error("flag not cleared");
  irq_gate_a:
    assert property (irq_request == (done && converter_irq_enable))
      else $error("irq gating wrong");
  idle_abort_a:
    assert property (idle_mode && busy |-> ##[1:2] !busy)
      else $error("idle did not abort");
  sw_start_a:
    assert property (start_set && !busy && !idle_mode |-> ##[1:SW_MAX] busy)
      else $error("start not taken");
  result_hold_a:
    assert property ($changed(result_high_byte) |-> $fell(busy))
      else $error("result moved");
endmodule

bind sac_top sac_properties #(
  .CLKS_PER_MC  (CLKS_PER_MC),
  .FAST_VARIANT (FAST_VARIANT)
) u_sac_properties (
  .clk                   (clk),
  .reset_n               (reset_n),
  .channel_sel           (channel_sel),
  .ext_start_en          (ext_start_en),
  .start_set             (start_set),
  .complete_clr          (complete_clr),
  .converter_irq_enable  (converter_irq_enable),
  .idle_mode             (idle_mode),
  .external_start_pin    (external_start_pin),
  .comparator_above      (comparator_above),
  .analog_channel        (analog_channel),
  .sample_switch         (sample_switch),
  .trial_voltage         (trial_voltage),
  .converter_control_reg (converter_control_reg),
  .result_high_byte      (result_high_byte),
  .irq_request           (irq_request)
);

// >>> verification/sar_adc_control_tb_top.sv
/* self-checking bench for sac_top with the analog side model.
   assumes a machine cycle shortened to four clocks */
`timescale 1ns/1ns
module sar_adc_control_tb_top
  import sac_pkg::*;
;
  localparam int MC = 4;
  logic                        clk = 1'b0;
  logic                        reset_n;
  logic [CHAN_BITS-1:0]        channel_sel;
  logic                        ext_en;
  logic                        start_set;
  logic                        clr;
  logic                        irq_en;
  logic                        idle_mode;
  logic                        pin;
  logic                        comp;
  logic [CHAN_BITS-1:0]        chan;
  logic                        sample_switch;
  logic [RESULT_BITS-1:0]      trial;
  logic [7:0]                  ctrl;
  logic [7:0]                  res_hi;
  logic                        irq;
  logic [CHAN_BITS-1:0]        chan_f;
  logic                        smp_f;
  logic [RESULT_BITS-1:0]      trial_f;
  logic                        comp_f;
  logic [7:0]                  ctrl_f;
  logic [7:0]                  res_hi_f;
  logic [7:0][RESULT_BITS-1:0] level;
  logic [RESULT_BITS-1:0]      last_res = 10'h000;
  int                          fail_count = 0;
  int                          num_checks = 0;
  wire                         busy = ctrl[CTRL_START_BIT];
  wire                         done = ctrl[CTRL_DONE_BIT];
  always #20 clk = ~clk;
  sac_top #(.CLKS_PER_MC(MC)) u_sac_top (
    .clk(clk), .reset_n(reset_n), .channel_sel(channel_sel),
    .ext_start_en(ext_en), .start_set(start_set), .complete_clr(clr),
    .converter_irq_enable(irq_en), .idle_mode(idle_mode),
    .external_start_pin(pin), .comparator_above(comp),
    .analog_channel(chan), .sample_switch(sample_switch),
    .trial_voltage(trial), .converter_control_reg(ctrl),
    .result_high_byte(res_hi), .irq_request(irq));
  sac_afe_model u_sac_afe_model (
    .level(level), .analog_channel(chan), .sample_switch(sample_switch),
    .trial_voltage(trial), .comparator_above(comp));
  // fast variant on the same stimulus, to time the shorter conversion
  sac_top #(.CLKS_PER_MC(MC), .FAST_VARIANT(1'b1)) u_sac_top_fast (
    .clk(clk), .reset_n(reset_n), .channel_sel(channel_sel),
    .ext_start_en(ext_en), .start_set(start_set), .complete_clr(clr),
    .converter_irq_enable(irq_en), .idle_mode(idle_mode),
    .external_start_pin(pin), .comparator_above(comp_f),
    .analog_channel(chan_f), .sample_switch(smp_f),
    .trial_voltage(trial_f), .converter_control_reg(ctrl_f),
    .result_high_byte(res_hi_f), .irq_request());
  sac_afe_model u_sac_afe_model_fast (
    .level(level), .analog_channel(chan_f), .sample_switch(smp_f),
    .trial_voltage(trial_f), .comparator_above(comp_f));
  // ****
  // tasks
  // ****
  task automatic close_out();
    if (fail_count == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // strict greater-than keeps a bit only above the trial level
  function automatic logic [9:0] exp_res(input logic [9:0] v);
    return (v == 10'h000) ? 10'h000 : v - 10'h001;
  endfunction
  task automatic wait_busy(input int lim);
    int n;
    n = 0;
    while (busy !== 1'b1 && n < lim)
    begin
      @(negedge clk);
      start_set = 1'b0;
      n++;
    end
    if (busy !== 1'b1)
    begin
      fail_count++;
      close_out();
    end
  endtask
  task automatic run_conv(input logic [9:0] v, input int lim,
                          input bit again, input bit abort);
    int nb;
    int ns;
    int nf;
    nb = 0;
    ns = 0;
    nf = 0;
    wait_busy(lim);
    while (busy === 1'b1 && nb < 1000)
    begin
      start_set = again && nb == 10;
      idle_mode = abort && nb > 40;
      ns += int'(sample_switch);
      nf += int'(ctrl_f[CTRL_START_BIT] === 1'b1);
      nb++;
      @(negedge clk);
    end
    start_set = 1'b0;
    idle_mode = 1'b0;
    if (nb >= 1000)
    begin
      fail_count++;
      close_out();
    end
    else if (abort)
    begin
      check(done, 1'b0);
      check(ctrl_f[CTRL_DONE_BIT], 1'b0);
      check(res_hi, last_res[9:2]);
      check(res_hi_f, last_res[9:2]);
    end
    else
    begin
      check(nb, CONV_MC_STD * MC);
      check(nf, CONV_MC_FAST * MC);
      check(ns, SAMPLE_MC * MC);
      check({res_hi, ctrl[7:6]}, exp_res(v));
      check({res_hi_f, ctrl_f[7:6]}, exp_res(v));
      check(done, 1'b1);
      last_res = exp_res(v);
    end
  endtask
  task automatic sw_channels();
    for (int ch = 0; ch < 8; ch++)
    begin
      channel_sel = ch[2:0];
      irq_en = ch[0];
      @(negedge clk);
      start_set = 1'b1;
      run_conv(level[ch], MC + 2, 1'b0, 1'b0);
      check(chan, ch[2:0]);
      check(ctrl[2:0], ch[2:0]);
      check(irq, ch[0]);
      clr = 1'b1;
      @(negedge clk);
      clr = 1'b0;
      check(done, 1'b0);
      check(irq, 1'b0);
    end
  endtask
  task automatic pin_start();
    channel_sel = 3'h2;
    pin = 1'b1;
    repeat (3 * MC) @(negedge clk);
    check(busy, 1'b0);
    pin = 1'b0;
    ext_en = 1'b1;
    repeat (3) @(negedge clk);
    pin = 1'b1;
    run_conv(level[2], MC + 6, 1'b1, 1'b0);
    check(ctrl[CTRL_EXT_BIT], 1'b1);
    repeat (3 * MC) @(negedge clk);
    check(busy, 1'b0);
    pin = 1'b0;
    clr = 1'b1;
    @(negedge clk);
    clr = 1'b0;
  endtask
  task automatic idle_abort();
    channel_sel = 3'h5;
    @(negedge clk);
    start_set = 1'b1;
    run_conv(level[5], MC + 2, 1'b0, 1'b1);
  endtask
  initial
  begin
    {start_set, clr, irq_en, idle_mode, ext_en, pin} = 6'h00;
    channel_sel = 3'h0;
    level = {10'h3ff, 10'h000, 10'h200, 10'h1ff,
             10'h155, 10'h2aa, 10'h001, 10'h300};
    reset_n = 1'b0;
    repeat (20) @(negedge clk);
    reset_n = 1'b1;
    repeat (6) @(negedge clk);
    sw_channels();
    pin_start();
    idle_abort();
    close_out();
  end
endmodule
